// ===== anr_pkg.sv
// Purpose: Constants for the auto-negotiation ability register set
// Assumes: Registers reached by 5-bit management register address
// Notes: Operation
package anr_pkg;
    localparam logic [4:0]  ADDR_ADV       = 5'h04;
    localparam logic [4:0]  ADDR_LP        = 5'h05;
    localparam logic [4:0]  ADDR_EXP       = 5'h06;
    localparam logic [4:0]  ADDR_REV       = 5'h10;
    localparam int          BIT_NP         = 15;
    localparam int          BIT_ACK        = 14;
    localparam int          BIT_RF         = 13;
    localparam int          BIT_PAUSE_LO   = 10;
    localparam int          BIT_LP_PAUSE   = 10;
    localparam int          BIT_T4         = 9;
    localparam int          BIT_TXFD       = 8;
    localparam int          BIT_TX         = 7;
    localparam int          BIT_10FD       = 6;
    localparam int          BIT_10         = 5;
    localparam int          BIT_PDF        = 4;
    localparam int          BIT_LP_NPA     = 3;
    localparam int          BIT_NPA        = 2;
    localparam int          BIT_PR         = 1;
    localparam int          BIT_LP_ANA     = 0;
    localparam int          BIT_REV_LO     = 6;
    localparam logic [1:0]  RST_PAUSE      = 2'h0;
    localparam logic [4:0]  RST_SELECTOR   = 5'h01;
    localparam logic        RST_TX_HD      = 1'b1;
    // Revision value is arbitrary
    localparam logic [3:0]  SILICON_REV    = 4'h3;
    localparam logic [15:0] ADV_WR_MASK    = 16'h2de0 | 16'h001f;
    localparam logic [15:0] LP_RST         = 16'h0001;
endpackage : anr_pkg

// ===== anr_latch_flag.sv
// Purpose: Latched-high event flag cleared by a register read
// Assumes: Event and read strobe are one-cycle pulses on core_clk_i
// Notes: Set wins over clear so no event is lost
`timescale 1ns/1ps
module anr_latch_flag (
    // Clock and reset
    input  wire logic core_clk_i,
    input  wire logic rst_n_i,
    // Event and clear
    input  wire logic event_i,
    input  wire logic rd_clr_i,
    // Flag
    output logic      flag_o
);
    logic flag_q;
    logic flag_d;

    assign flag_d = event_i | (flag_q & ~rd_clr_i);
    assign flag_o = flag_q;

    always_ff @(posedge core_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            flag_q <= 1'b0;
        else
            flag_q <= flag_d;
    end
endmodule : anr_latch_flag

// ===== anr_regs.sv
// Purpose: Auto-negotiation advertisement, partner, expansion and revision registers
// Assumes: Management access is a read or write strobe with 5-bit address, one cycle each
// Notes: Read data is registered one cycle after the read strobe
`timescale 1ns/1ps
module anr_regs (
    // Clock and reset
    input  wire logic        core_clk_i,
    input  wire logic        rst_n_i,
    // Mode straps: tx full duplex, 10 full duplex, 10 half duplex
    input  wire logic        strap_txfd_i,
    input  wire logic        strap_10fd_i,
    input  wire logic        strap_10_i,
    // Management access
    input  wire logic [4:0]  mgmt_addr_i,
    input  wire logic        mgmt_wr_i,
    input  wire logic [15:0] mgmt_wdata_i,
    input  wire logic        mgmt_rd_i,
    output logic [15:0]      mgmt_rdata_o,
    output logic             mgmt_rvalid_o,
    // Negotiation engine side
    input  wire logic        lp_word_valid_i,
    input  wire logic [15:0] lp_word_i,
    input  wire logic        lp_an_able_i,
    input  wire logic        page_rx_i,
    input  wire logic        pd_fault_i,
    // Advertised word to the negotiation engine
    output logic [15:0]      adv_word_o
);
    logic [15:0] adv_q;
    logic [15:0] adv_d;
    logic [15:0] lp_q;
    logic [15:0] lp_d;
    logic        lp_ana_q;
    logic        strap_take_q;
    logic [15:0] rdata_q;
    logic [15:0] rdata_d;
    logic        rvalid_q;
    logic        pr_flag;
    logic        pdf_flag;
    logic [15:0] adv_view;
    logic [15:0] lp_view;
    logic [15:0] exp_view;
    logic [15:0] rev_view;
    logic        wr_adv;
    logic        rd_exp;
    logic [15:0] lp_mask;

    assign wr_adv = mgmt_wr_i & (mgmt_addr_i == anr_pkg::ADDR_ADV);
    assign rd_exp = mgmt_rd_i & (mgmt_addr_i == anr_pkg::ADDR_EXP);

    // Only writable bits change; next page, T4 and reserved stay zero
    assign adv_d = wr_adv ? (mgmt_wdata_i & anr_pkg::ADV_WR_MASK) : adv_q;

    // Partner fields kept: rf, pause, tx-fd, tx, 10-fd, 10, selector; ack is forced set
    assign lp_mask = 16'h0000 | (16'h1 << anr_pkg::BIT_RF) | (16'h1 << anr_pkg::BIT_LP_PAUSE)
                     | 16'h01ff & ~(16'h1 << anr_pkg::BIT_T4);
    assign lp_d = lp_word_valid_i
                  ? ((lp_word_i & lp_mask) | (16'h1 << anr_pkg::BIT_ACK))
                  : lp_q;

    assign adv_view = adv_q;
    assign lp_view  = lp_q;
    assign exp_view = {11'h000, pdf_flag, 1'b0, 1'b0, pr_flag, lp_ana_q};
    assign rev_view = 16'h0000 | ({12'h000, anr_pkg::SILICON_REV} << anr_pkg::BIT_REV_LO);

    assign rdata_d = (mgmt_addr_i == anr_pkg::ADDR_ADV) ? adv_view :
                     (mgmt_addr_i == anr_pkg::ADDR_LP)  ? lp_view  :
                     (mgmt_addr_i == anr_pkg::ADDR_EXP) ? exp_view :
                     (mgmt_addr_i == anr_pkg::ADDR_REV) ? rev_view : 16'h0000;

    assign mgmt_rdata_o  = rdata_q;
    assign mgmt_rvalid_o = rvalid_q;
    assign adv_word_o    = adv_q;

    // Read of expansion returns the flag then clears it
    anr_latch_flag u_page_rx (
        .core_clk_i (core_clk_i),
        .rst_n_i    (rst_n_i),
        .event_i    (page_rx_i),
        .rd_clr_i   (rd_exp),
        .flag_o     (pr_flag)
    );

    anr_latch_flag u_pd_fault (
        .core_clk_i (core_clk_i),
        .rst_n_i    (rst_n_i),
        .event_i    (pd_fault_i),
        .rd_clr_i   (rd_exp),
        .flag_o     (pdf_flag)
    );

    // Straps cannot load under async reset, so they are taken at the first edge after release unless an advertisement write lands on that edge
    always_ff @(posedge core_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            strap_take_q <= 1'b1;
            adv_q        <= 16'h0000 | ({15'h0000, anr_pkg::RST_TX_HD} << anr_pkg::BIT_TX)
                            | {11'h000, anr_pkg::RST_SELECTOR}
                            | ({14'h0000, anr_pkg::RST_PAUSE} << anr_pkg::BIT_PAUSE_LO);
        end
        else
        begin
            strap_take_q <= 1'b0;
            if (strap_take_q && !wr_adv)
                adv_q <= adv_q | ({15'h0000, strap_txfd_i} << anr_pkg::BIT_TXFD)
                               | ({15'h0000, strap_10fd_i} << anr_pkg::BIT_10FD)
                               | ({15'h0000, strap_10_i} << anr_pkg::BIT_10);
            else
                adv_q <= adv_d;
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            lp_q     <= anr_pkg::LP_RST;
            lp_ana_q <= 1'b0;
        end
        else
        begin
            lp_q     <= lp_d;
            lp_ana_q <= lp_ana_q | lp_an_able_i;
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            rdata_q  <= 16'h0000;
            rvalid_q <= 1'b0;
        end
        else
        begin
            rvalid_q <= mgmt_rd_i;
            if (mgmt_rd_i)
                rdata_q <= rdata_d;
        end
    end
endmodule : anr_regs

// ===== anr_regs_asserts.sv
// Purpose: Port assertions for anr_regs
// Assumes: One clock, async active-low reset
// Notes: Read data lands one cycle after the strobe
`timescale 1ns/1ps
module anr_regs_asserts (
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic [4:0] mgmt_addr_i,
    input wire logic mgmt_wr_i,
    input wire logic [15:0] mgmt_wdata_i,
    input wire logic mgmt_rd_i,
    input wire logic [15:0] mgmt_rdata_o,
    input wire logic mgmt_rvalid_o,
    input wire logic page_rx_i,
    input wire logic [15:0] adv_word_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);
    wire logic wr_adv = mgmt_wr_i && mgmt_addr_i == anr_pkg::ADDR_ADV;
    wire logic rd_exp = mgmt_rd_i && mgmt_addr_i == anr_pkg::ADDR_EXP;
    AST_RVALID: assert property (mgmt_rvalid_o == $past(mgmt_rd_i))
        else $error("rvalid timing");
    AST_ADV_RSVD: assert property ((adv_word_o & ~anr_pkg::ADV_WR_MASK) == 16'h0)
        else $error("adv fixed bit set");
    AST_ADV_WR: assert property (wr_adv |=> adv_word_o == ($past(mgmt_wdata_i) & anr_pkg::ADV_WR_MASK))
        else $error("adv write lost");
    // Straps land at the first edge after release, so hold is checked from the third edge on
    AST_ADV_HOLD: assert property ($past(rst_n_i, 2) && $past(rst_n_i) && !$past(wr_adv) |-> $stable(adv_word_o))
        else $error("adv changed");
    AST_REV: assert property (mgmt_rd_i && mgmt_addr_i == anr_pkg::ADDR_REV
        |=> mgmt_rdata_o == {6'h0, anr_pkg::SILICON_REV, 6'h0}) else $error("bad revision");
    AST_UNMAPPED: assert property (mgmt_rd_i && !(mgmt_addr_i inside {5'h04, 5'h05, 5'h06, 5'h10})
        |=> mgmt_rdata_o == 16'h0) else $error("unmapped read");
    AST_EXP_RSVD: assert property (rd_exp |=> mgmt_rdata_o[15:5] == 11'h0 && mgmt_rdata_o[3:2] == 2'h0)
        else $error("expansion reserved");
    AST_PR_SET: assert property (page_rx_i ##1 rd_exp |=> mgmt_rdata_o[1])
        else $error("page flag lost");
endmodule : anr_regs_asserts
bind anr_regs anr_regs_asserts u_anr_regs_asserts (.*);

// ===== anr_mgmt_model.sv
// Purpose: Management controller model for anr_regs
// Assumes: Task entered 1ns after a rising edge
// Notes: Ports named after the pins they drive; one idle cycle per access
`timescale 1ns/1ps
module anr_mgmt_model (
    input wire logic core_clk_i,
    output logic [4:0] mgmt_addr_i,
    output logic mgmt_wr_i,
    output logic [15:0] mgmt_wdata_i,
    output logic mgmt_rd_i
);
    initial {mgmt_addr_i, mgmt_wr_i, mgmt_wdata_i, mgmt_rd_i} = '0;
    task automatic acc(input logic w, input logic [4:0] a, input logic [15:0] d);
        {mgmt_addr_i, mgmt_wdata_i, mgmt_wr_i, mgmt_rd_i} = {a, d, w, !w};
        @(posedge core_clk_i);
        #1 {mgmt_wr_i, mgmt_rd_i, mgmt_wdata_i} = {2'h0, ~d};
        @(posedge core_clk_i);
        #1;
    endtask : acc
endmodule : anr_mgmt_model

// ===== test_anr_regs.sv
// Purpose: Self-checking bench for anr_regs
// Assumes: Inputs move 1ns after the rising edge
// Notes: Read words checked against a queue of expectations
`timescale 1ns/1ps
module test_anr_regs;
    logic core_clk_i = 0, rst_n_i = 0, lp_word_valid_i = 0, lp_an_able_i = 0, page_rx_i = 0, pd_fault_i = 0;
    logic strap_txfd_i, strap_10fd_i, strap_10_i, mgmt_wr_i, mgmt_rd_i, mgmt_rvalid_o;
    logic [4:0] mgmt_addr_i;
    logic [15:0] lp_word_i = 0, mgmt_wdata_i, mgmt_rdata_o, adv_word_o, w;
    logic [15:0] exp_q[$];
    int n_fail = 0, n_checks = 0, seed = 32'h5f36c979;
    anr_mgmt_model u_anr_mgmt_model (.*);
    anr_regs u_anr_regs (.*);
    initial forever #2.5 core_clk_i = ~core_clk_i;
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("Error at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic rd_exp(input logic [4:0] ra, input logic [15:0] re);
        exp_q.push_back(re);
        u_anr_mgmt_model.acc(1'b0, ra, 16'h0);
    endtask : rd_exp
    task automatic tally_and_finish;
        $display("Checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : tally_and_finish
    always @(negedge core_clk_i)
        if (mgmt_rvalid_o === 1'b1)
            check(mgmt_rdata_o, exp_q.pop_front());
    initial
    begin
        #5000;
        n_fail++;
        tally_and_finish;
    end
    initial
    begin
        {strap_txfd_i, strap_10fd_i, strap_10_i} = 3'($random(seed));
        repeat (12) @(posedge core_clk_i);
        #1 rst_n_i = 1;
        @(posedge core_clk_i);
        #1 w = 16'h0081 | {strap_txfd_i, 1'b0, strap_10fd_i, strap_10_i, 5'h0};
        rd_exp(anr_pkg::ADDR_ADV, w);
        rd_exp(anr_pkg::ADDR_LP, anr_pkg::LP_RST);
        rd_exp(anr_pkg::ADDR_EXP, 16'h0);
        rd_exp(anr_pkg::ADDR_REV, {6'h0, anr_pkg::SILICON_REV, 6'h0});
        rd_exp(5'h1f, 16'h0);
        $display("Reset values done");
        for (int i = 0; i < 4; i++)
        begin
            w = 16'($random(seed));
            w[11:10] = 2'(i);
            u_anr_mgmt_model.acc(1'b1, anr_pkg::ADDR_ADV, w);
            rd_exp(anr_pkg::ADDR_ADV, w & anr_pkg::ADV_WR_MASK);
        end
        $display("Advertisement writes done");
        {lp_word_i, lp_word_valid_i, lp_an_able_i} = {16'($random(seed)), 2'h3};
        #5 lp_word_valid_i = 0;
        u_anr_mgmt_model.acc(1'b1, anr_pkg::ADDR_LP, ~lp_word_i);
        rd_exp(anr_pkg::ADDR_LP, (lp_word_i & 16'h25ff) | 16'h4000);
        {page_rx_i, pd_fault_i} = 2'h3;
        #5 {page_rx_i, pd_fault_i} = 2'h0;
        rd_exp(anr_pkg::ADDR_EXP, 16'h0013);
        rd_exp(anr_pkg::ADDR_EXP, 16'h0001);
        // New page in the cycle of the clearing read and held through the idle cycle after it, so the flag ends up set either way
        page_rx_i = 1;
        rd_exp(anr_pkg::ADDR_EXP, 16'h0001);
        page_rx_i = 0;
        rd_exp(anr_pkg::ADDR_EXP, 16'h0003);
        rd_exp(anr_pkg::ADDR_EXP, 16'h0001);
        $display("Partner and flags done");
        tally_and_finish;
    end
endmodule : test_anr_regs
